// File: hdl/fpas_consts.svh
`ifndef FPAS_CONSTS_SVH
`define FPAS_CONSTS_SVH
// Register byte offsets.
`define FPAS_OFF_STATUS   12'h000
`define FPAS_OFF_CONTROL  12'h004
`define FPAS_OFF_FREQ     12'h008
`define FPAS_OFF_CFG      12'h00C
// Frequency register fields.
`define FPAS_FREQ_TX_LSB  4
`define FPAS_FREQ_RX_LSB  17
// Reset values.
`define FPAS_RST_PLAN     2'h0
`define FPAS_RST_TX_MHZ   13'h166C
`define FPAS_RST_RX_MHZ   13'h16B1
// Band limits and spacing in MHz.
`define FPAS_LO_MIN       13'h1667
`define FPAS_LO_MAX       13'h168B
`define FPAS_HI_MIN       13'h16AC
`define FPAS_HI_MAX       13'h16D0
`define FPAS_SPACING_MHZ  13'h0045
// Default addresses for the routed side choices.
`define FPAS_FAR_ETH_IP   32'h0A0B0102
`define FPAS_FAR_MGMT_IP  32'h0A0C0102
`define FPAS_NEAR_ETH_IP  32'h0A020102
`define FPAS_NEAR_MGMT_IP 32'h0A0D0102
// Timing.
`define FPAS_CLK_MHZ      200
`define FPAS_DEBOUNCE_US  20000
`define FPAS_FLASH_US     250000
`define FPAS_COMMIT_US    2000000
`define FPAS_LAST_POS     4'hE
`endif

// File: hdl/fpas_pkg.sv
package fpas_pkg;
	typedef enum logic [1:0] {COL_OFF, COL_GREEN, COL_ORANGE, COL_RED} fpas_col_t;
	typedef enum logic [1:0] {ST_STARTUP, ST_IDLE, ST_SELECT, ST_BLANK} fpas_state_t;
	typedef enum logic [1:0] {PLAN_A, PLAN_B, PLAN_C, PLAN_D} fpas_plan_t;
endpackage

// File: hdl/fpas_top.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "fpas_consts.svh"
// What this block does
// - System LED green healthy, orange comms errors, red comms down.
// - Payload LED green healthy, orange on AIS, red on loss of signal.
// - Link LED green healthy, orange FEC correcting, red FEC failing.
// - Red or orange conditions latch and flash in that colour until cleared.
// - Selected position shown as link, payload, system, green, orange, red, then flashing green and orange.
// - Position one clears latched LED indications and associated alarms.
// - Position two erases the event log.
// - Position three resets the indoor unit, stored configuration kept.
// - Position four loads routed far-side defaults with its addresses.
// - Position five loads routed near-side defaults with its addresses.
// - Position six loads routed defaults for the current side.
// - Positions seven and eight load bridged far and near defaults.
// - Position twelve selects E1 tributaries.
// - Position thirteen selects T1 tributaries.
// - Position fourteen locks out positions four and above.
// - Button held through power-on reset re-enables all positions.
// - Stepping past fourteen blanks LEDs, then selection restarts at one.
// - Plan D accepts 1 MHz steps within the lower and upper sub-bands.
// - Fixed plans keep transmit and receive 69 MHz apart.
// - Two site-alarm contacts are readable by management software.
// - Two relay outputs are set by software.
module fpas_top #(
	parameter int unsigned DEBOUNCE_CYC = `FPAS_DEBOUNCE_US * `FPAS_CLK_MHZ,
	parameter int unsigned FLASH_CYC    = `FPAS_FLASH_US * `FPAS_CLK_MHZ,
	parameter int unsigned COMMIT_CYC   = `FPAS_COMMIT_US * `FPAS_CLK_MHZ,
	parameter logic [31:0] BR_FAR_IP    = 32'h0A000001,
	parameter logic [31:0] BR_NEAR_IP   = 32'h0A000002
) (
	// Clock and reset.
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	// Alarm sources, same clock.
	input  wire logic                 ou_comms_err,
	input  wire logic                 ou_comms_down,
	input  wire logic                 trib_ais,
	input  wire logic                 trib_los,
	input  wire logic                 fec_correcting,
	input  wire logic                 fec_uncorrectable,
	// Front panel pins.
	input  wire logic                 button_pin,
	input  wire logic [1:0]           site_alarm_pin,
	output logic [1:0]                relay_out,
	output fpas_pkg::fpas_col_t       led_link,
	output fpas_pkg::fpas_col_t       led_payload,
	output fpas_pkg::fpas_col_t       led_system,
	// Stored configuration side.
	input  wire logic                 nv_lockout,
	input  wire logic                 cfg_cur_near,
	output logic                      nv_lockout_wr,
	output logic                      nv_lockout_val,
	output logic                      alarm_clear,
	output logic                      log_clear,
	output logic                      unit_reset,
	output logic                      cfg_load,
	output logic                      cfg_bridged,
	output logic                      cfg_near,
	output logic [31:0]               cfg_eth_ip,
	output logic [31:0]               cfg_mgmt_ip,
	output logic                      trib_t1,
	// Radio channel settings.
	output fpas_pkg::fpas_plan_t      freq_plan,
	output logic [12:0]               tx_mhz,
	output logic [12:0]               rx_mhz
);
	import fpas_pkg::*;

	// Pin synchronisers; the first stages feed only the second stages.
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {site_alarm_pin, button_pin};
			sync2_r <= sync1_r;
		end
	end
	wire       btn_s  = sync2_r[0];
	wire [1:0] site_s = sync2_r[2:1];

	// Debounce: the button must hold a new level for the full count.
	logic        btn_db_r;
	logic [31:0] db_cnt_r;
	wire         db_diff = btn_s != btn_db_r;
	wire         db_done = db_diff && (db_cnt_r == DEBOUNCE_CYC - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_db_r <= 1'b0;
			db_cnt_r <= 32'h0;
		end else begin
			db_cnt_r <= (db_diff && !db_done) ? db_cnt_r + 32'h1 : 32'h0;
			if (db_done)
				btn_db_r <= btn_s;
		end
	end
	wire press = db_done && btn_s;

	// Selection machine and release timer.
	fpas_state_t st_r;
	fpas_state_t st_nxt;
	logic [3:0]  pos_r;
	logic [3:0]  pos_nxt;
	logic [31:0] idle_cnt_r;
	logic [1:0]  boot_cnt_r;
	logic        lock_r;
	wire         idle_done = !btn_db_r && (idle_cnt_r == COMMIT_CYC - 1);
	wire         commit = (st_r == ST_SELECT) && idle_done && !press;
	wire         allowed = !(lock_r && pos_r >= 4'h4);
	wire         act = commit && allowed;

	// Next state; a press always wins over the release timeout.
	always_comb begin
		st_nxt = st_r;
		pos_nxt = pos_r;
		case (st_r)
			ST_STARTUP: begin
				if (boot_cnt_r == 2'h3)
					st_nxt = ST_IDLE;
			end
			ST_IDLE: begin
				if (press) begin
					st_nxt = ST_SELECT;
					pos_nxt = 4'h1;
				end
			end
			ST_SELECT: begin
				if (press && pos_r == `FPAS_LAST_POS) begin
					st_nxt = ST_BLANK;
					pos_nxt = 4'h0;
				end else if (press) begin
					pos_nxt = pos_r + 4'h1;
				end else if (idle_done) begin
					st_nxt = ST_IDLE;
					pos_nxt = 4'h0;
				end
			end
			ST_BLANK: begin
				if (press) begin
					st_nxt = ST_SELECT;
					pos_nxt = 4'h1;
				end else if (idle_done) begin
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
				pos_nxt = 4'h0;
			end
		endcase
	end

	// State registers; the timer restarts on any press or while held.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_STARTUP;
			pos_r <= 4'h0;
			idle_cnt_r <= 32'h0;
			boot_cnt_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			pos_r <= pos_nxt;
			idle_cnt_r <= (press || btn_db_r || st_nxt != st_r) ? 32'h0 : idle_cnt_r + 32'h1;
			if (st_r == ST_STARTUP)
				boot_cnt_r <= boot_cnt_r + 2'h1;
		end
	end

	// Lockout is taken from storage once the synchroniser has settled after reset.
	// A button held at that moment cancels it and writes the cancel back.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= 1'b0;
			nv_lockout_wr <= 1'b0;
			nv_lockout_val <= 1'b0;
		end else begin
			nv_lockout_wr <= 1'b0;
			if (st_r == ST_STARTUP && boot_cnt_r == 2'h3) begin
				lock_r <= nv_lockout && !btn_s;
				nv_lockout_wr <= nv_lockout && btn_s;
				nv_lockout_val <= 1'b0;
			end else if (act && pos_r == 4'hE) begin
				lock_r <= 1'b1;
				nv_lockout_wr <= 1'b1;
				nv_lockout_val <= 1'b1;
			end
		end
	end

	// Position actions, two to eight each a single pulse, twelve and thirteen set trib_t1; nine to eleven fall through.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			log_clear <= 1'b0;
			unit_reset <= 1'b0;
			cfg_load <= 1'b0;
			cfg_bridged <= 1'b0;
			cfg_near <= 1'b0;
			cfg_eth_ip <= 32'h0;
			cfg_mgmt_ip <= 32'h0;
			trib_t1 <= 1'b0;
		end else begin
			log_clear <= act && pos_r == 4'h2;
			unit_reset <= act && pos_r == 4'h3;
			cfg_load <= act && pos_r >= 4'h4 && pos_r <= 4'h8;
			if (act && (pos_r == 4'h4 || (pos_r == 4'h6 && !cfg_cur_near))) begin
				cfg_bridged <= 1'b0;
				cfg_near <= 1'b0;
				cfg_eth_ip <= `FPAS_FAR_ETH_IP;
				cfg_mgmt_ip <= `FPAS_FAR_MGMT_IP;
			end
			if (act && (pos_r == 4'h5 || (pos_r == 4'h6 && cfg_cur_near))) begin
				cfg_bridged <= 1'b0;
				cfg_near <= 1'b1;
				cfg_eth_ip <= `FPAS_NEAR_ETH_IP;
				cfg_mgmt_ip <= `FPAS_NEAR_MGMT_IP;
			end
			if (act && (pos_r == 4'h7 || pos_r == 4'h8)) begin
				cfg_bridged <= 1'b1;
				cfg_near <= pos_r == 4'h8;
				cfg_eth_ip <= (pos_r == 4'h8) ? BR_NEAR_IP : BR_FAR_IP;
				cfg_mgmt_ip <= (pos_r == 4'h8) ? BR_NEAR_IP : BR_FAR_IP;
			end
			if (act && pos_r == 4'hC)
				trib_t1 <= 1'b0;
			if (act && pos_r == 4'hD)
				trib_t1 <= 1'b1;
		end
	end

	// Alarm conditions per LED: 0 link, 1 payload, 2 system.
	wire [2:0] red_cond = {ou_comms_down, trib_los, fec_uncorrectable};
	wire [2:0] org_cond = {ou_comms_err, trib_ais, fec_correcting};
	wire       sw_clear;
	wire       hist_clr = (act && pos_r == 4'h1) || sw_clear;
	logic [2:0] hist_red_r;
	logic [2:0] hist_org_r;

	// History latches; a new alarm in the clearing cycle survives the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_red_r <= 3'h0;
			hist_org_r <= 3'h0;
			alarm_clear <= 1'b0;
		end else begin
			hist_red_r <= red_cond | (hist_red_r & {3{!hist_clr}});
			hist_org_r <= org_cond | (hist_org_r & {3{!hist_clr}});
			alarm_clear <= hist_clr;
		end
	end

	// Flash divider gives the on and off phase for historic alarms.
	logic [31:0] fl_cnt_r;
	logic        fl_on_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl_cnt_r <= 32'h0;
			fl_on_r <= 1'b1;
		end else if (fl_cnt_r == FLASH_CYC - 1) begin
			fl_cnt_r <= 32'h0;
			fl_on_r <= !fl_on_r;
		end else begin
			fl_cnt_r <= fl_cnt_r + 32'h1;
		end
	end

	// Position display: LED index and colour group from the position.
	wire [3:0] pos_m1 = pos_r - 4'h1;
	wire [1:0] pos_idx = 2'(pos_m1 % 4'h3);
	wire [2:0] pos_grp = 3'(pos_m1 / 4'h3);
	fpas_col_t led_r [3];
	fpas_col_t led_nxt [3];

	// One colour selector per LED.
	for (genvar i = 0; i < 3; i++) begin : g_led
		wire       mine = pos_idx == 2'(i);
		wire       live_red = red_cond[i];
		wire       live_org = org_cond[i];
		fpas_col_t sel_col;
		fpas_col_t stat_col;
		assign sel_col = !mine ? COL_OFF :
			(pos_grp == 3'h0 || (pos_grp == 3'h3 && fl_on_r)) ? COL_GREEN :
			(pos_grp == 3'h1 || (pos_grp == 3'h4 && fl_on_r)) ? COL_ORANGE :
			(pos_grp == 3'h2) ? COL_RED : COL_OFF;
		assign stat_col = live_red ? COL_RED :
			live_org ? COL_ORANGE :
			(hist_red_r[i] && !fl_on_r) ? COL_OFF :
			hist_red_r[i] ? COL_RED :
			(hist_org_r[i] && !fl_on_r) ? COL_OFF :
			hist_org_r[i] ? COL_ORANGE : COL_GREEN;
		assign led_nxt[i] = (st_r == ST_SELECT) ? sel_col :
			(st_r == ST_IDLE) ? stat_col : COL_OFF;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				led_r[i] <= COL_OFF;
			else
				led_r[i] <= led_nxt[i];
		end
	end
	assign led_link = led_r[0];
	assign led_payload = led_r[1];
	assign led_system = led_r[2];

	// APB decode; the slave never waits, so pready is tied high.
	wire        setup = psel && !penable;
	wire        access = psel && penable;
	wire        sel_stat = paddr == `FPAS_OFF_STATUS;
	wire        sel_ctrl = paddr == `FPAS_OFF_CONTROL;
	wire        sel_freq = paddr == `FPAS_OFF_FREQ;
	wire        sel_cfg = paddr == `FPAS_OFF_CFG;
	wire        mapped = sel_stat || sel_ctrl || sel_freq || sel_cfg;
	wire [12:0] w_tx = pwdata[`FPAS_FREQ_TX_LSB +: 13];
	wire [12:0] w_rx = pwdata[`FPAS_FREQ_RX_LSB +: 13];
	wire        tx_lo = w_tx >= `FPAS_LO_MIN && w_tx <= `FPAS_LO_MAX;
	wire        tx_hi = w_tx >= `FPAS_HI_MIN && w_tx <= `FPAS_HI_MAX;
	wire        rx_lo = w_rx >= `FPAS_LO_MIN && w_rx <= `FPAS_LO_MAX;
	wire        rx_hi = w_rx >= `FPAS_HI_MIN && w_rx <= `FPAS_HI_MAX;
	wire        w_is_d = pwdata[1:0] == 2'h3;
	wire        plan_d_ok = (tx_lo && rx_hi) || (tx_hi && rx_lo);
	wire        fixed_ok = (w_rx == w_tx + `FPAS_SPACING_MHZ) || (w_tx == w_rx + `FPAS_SPACING_MHZ);
	wire        freq_ok = pstrb == 4'hF && (w_is_d ? plan_d_ok : fixed_ok);
	wire        freq_bad = pwrite && sel_freq && !freq_ok;
	wire        freq_we = access && pwrite && sel_freq && freq_ok;
	wire        ctrl_we = access && pwrite && sel_ctrl && pstrb[0];
	assign pready = 1'b1;
	assign pslverr = access && (!mapped || freq_bad);
	assign sw_clear = ctrl_we && pwdata[2];

	// Read data assembled from live and latched state.
	wire [31:0] stat_word = {11'h0, cfg_near, site_s, trib_t1, lock_r, pos_r,
		hist_org_r, hist_red_r, org_cond, red_cond};
	wire [31:0] freq_word = {2'h0, rx_mhz, tx_mhz, 2'h0, freq_plan};
	wire [31:0] cfg_word = {30'h0, cfg_bridged, trib_t1};
	wire [31:0] rd_word = sel_stat ? stat_word :
		sel_ctrl ? {30'h0, relay_out} :
		sel_freq ? freq_word :
		sel_cfg ? cfg_word : 32'h0;

	// Registers; read data is captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			relay_out <= 2'h0;
			freq_plan <= PLAN_A;
			tx_mhz <= `FPAS_RST_TX_MHZ;
			rx_mhz <= `FPAS_RST_RX_MHZ;
		end else begin
			if (setup && !pwrite)
				prdata <= rd_word;
			if (ctrl_we)
				relay_out <= pwdata[1:0];
			if (freq_we) begin
				freq_plan <= fpas_plan_t'(pwdata[1:0]);
				tx_mhz <= w_tx;
				rx_mhz <= w_rx;
			end
		end
	end

	// Checks.
	AST_SYS_RED: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_IDLE && st_nxt == ST_IDLE && ou_comms_down) |=> led_system == COL_RED)
		else $error("system LED not red on comms down");
	AST_PAY_ORG: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_IDLE && st_nxt == ST_IDLE && trib_ais && !trib_los) |=> led_payload == COL_ORANGE)
		else $error("payload LED not orange on AIS");
	AST_LINK_GRN: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_IDLE && st_nxt == ST_IDLE && red_cond == 3'h0 && org_cond == 3'h0
		&& hist_red_r == 3'h0 && hist_org_r == 3'h0) |=> led_link == COL_GREEN)
		else $error("link LED not green while healthy");
	AST_HIST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		fec_uncorrectable ##1 (!hist_clr)[*3] |=> hist_red_r[0])
		else $error("red history lost without a clear");
	AST_POS_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_SELECT && pos_r == 4'h1) |=> led_link == COL_GREEN && led_system == COL_OFF)
		else $error("position one not shown on link LED");
	AST_LOG: assert property (@(posedge pclk) disable iff (!presetn)
		(commit && pos_r == 4'h2) |=> log_clear ##1 !log_clear)
		else $error("log clear not a single pulse");
	AST_RESET: assert property (@(posedge pclk) disable iff (!presetn)
		unit_reset |-> $past(commit) && $past(pos_r) == 4'h3 && !cfg_load)
		else $error("unit reset without position three");
	AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
		(lock_r && commit && pos_r >= 4'h4) |=> !cfg_load && $stable(trib_t1))
		else $error("locked position acted");
	AST_T1: assert property (@(posedge pclk) disable iff (!presetn)
		(act && pos_r == 4'hD) |=> trib_t1)
		else $error("T1 not selected");
	AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_SELECT && pos_r == 4'hE && press) |=> st_r == ST_BLANK ##1 (led_link == COL_OFF))
		else $error("no blank after last position");
	AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_SELECT && press && pos_r < 4'hE) |=> pos_r == $past(pos_r) + 4'h1)
		else $error("press did not advance one position");
	AST_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
		(freq_we && !w_is_d) |=> (rx_mhz - tx_mhz == `FPAS_SPACING_MHZ)
		|| (tx_mhz - rx_mhz == `FPAS_SPACING_MHZ))
		else $error("fixed plan spacing broken");
endmodule

// File: testbench/fpas_operator.sv
`timescale 1ns/1ps
// Operator at the front panel: a push button whose contact bounces on every change made through settle.
module fpas_operator #(
	parameter int unsigned DEB = 4
) (
	// Clock that paces the operator.
	input  wire logic pclk,
	// Button contact, high while pressed.
	output logic      button_pin
);
	initial button_pin = 1'b0;

	// Bounce for three cycles, then hold the level well past the debounce span.
	task automatic settle(input logic v);
		int i;
		for (i = 0; i < DEB + 7; i++) begin
			@(posedge pclk);
			button_pin <= (i < 3) ? v ^ i[0] : v;
		end
	endtask

	// One press and release per position; a count of fifteen overruns fourteen and blanks the panel.
	task automatic select(input int n);
		int k;
		for (k = 0; k < n; k++) begin
			settle(1'b1);
			settle(1'b0);
		end
	endtask

	// Hold the button in across a power-on reset to undo the lockout.
	task automatic hold(input logic v);
		@(posedge pclk);
		button_pin <= v;
	endtask
endmodule

// File: testbench/tb_fpas_top.sv
`timescale 1ns/1ps
`include "fpas_consts.svh"
module tb_fpas_top;
	import fpas_pkg::*;
	localparam int unsigned DEB   = 4;
	localparam int unsigned CMT   = 20;
	localparam logic [31:0] BFAR  = 32'h0A000011;
	localparam logic [31:0] BNEAR = 32'h0A000012;
	logic        pclk, presetn, psel, penable, pwrite, nv_lockout, cfg_cur_near, pready, pslverr, e;
	logic        nv_lockout_wr, nv_lockout_val, alarm_clear, log_clear, unit_reset, cfg_load, wr_val;
	logic        cfg_bridged, cfg_near, trib_t1, button_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, fr, cfg_eth_ip, cfg_mgmt_ip;
	logic [3:0]  pstrb;
	logic [5:0]  alm;
	logic [1:0]  site_alarm_pin, relay_out;
	logic [12:0] tx_mhz, rx_mhz;
	fpas_col_t   led_link, led_payload, led_system;
	fpas_plan_t  freq_plan;
	int          n_mismatch, num_checks, cnt [5], s [5], lock, i, p;
	int          plist [11] = '{2, 3, 4, 5, 6, 7, 8, 9, 13, 12, 14};
	logic [1:0]  fpl [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
	logic [12:0] ftx [5] = '{13'h1667, 13'h1667, 13'h168B, 13'h168C, 13'h16D0};
	logic [12:0] frx [5] = '{13'h16AC, 13'h16AD, 13'h16AC, 13'h16AC, 13'h1667};
	wire  [5:0]  leds = {led_system, led_payload, led_link};

	fpas_top #(.DEBOUNCE_CYC(DEB), .FLASH_CYC(8), .COMMIT_CYC(CMT), .BR_FAR_IP(BFAR), .BR_NEAR_IP(BNEAR)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.fec_correcting(alm[0]), .fec_uncorrectable(alm[1]), .trib_ais(alm[2]), .trib_los(alm[3]),
		.ou_comms_err(alm[4]), .ou_comms_down(alm[5]), .button_pin(button_pin),
		.site_alarm_pin(site_alarm_pin), .relay_out(relay_out), .led_link(led_link),
		.led_payload(led_payload), .led_system(led_system), .nv_lockout(nv_lockout),
		.cfg_cur_near(cfg_cur_near), .nv_lockout_wr(nv_lockout_wr), .nv_lockout_val(nv_lockout_val),
		.alarm_clear(alarm_clear), .log_clear(log_clear), .unit_reset(unit_reset), .cfg_load(cfg_load),
		.cfg_bridged(cfg_bridged), .cfg_near(cfg_near), .cfg_eth_ip(cfg_eth_ip), .cfg_mgmt_ip(cfg_mgmt_ip),
		.trib_t1(trib_t1), .freq_plan(freq_plan), .tx_mhz(tx_mhz), .rx_mhz(rx_mhz)
	);
	fpas_operator #(.DEB(DEB)) i_op (.pclk(pclk), .button_pin(button_pin));

	// Free-running 200 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Count action pulses, since a pulse lasts one cycle and could otherwise slip past a check.
	always @(posedge pclk) begin
		cnt[0] <= cnt[0] + int'(alarm_clear === 1'b1);
		cnt[1] <= cnt[1] + int'(log_clear === 1'b1);
		cnt[2] <= cnt[2] + int'(unit_reset === 1'b1);
		cnt[3] <= cnt[3] + int'(cfg_load === 1'b1);
		cnt[4] <= cnt[4] + int'(nv_lockout_wr === 1'b1);
		if (nv_lockout_wr === 1'b1) wr_val <= nv_lockout_val;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		num_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, g, x);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	// An edge passes after the release, so back-to-back calls never drive psel twice at once.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Pulses expected from a committed position; a lockout silences four and above.
	function automatic logic [4:0] msk(input int p);
		if (lock != 0 && p >= 4) return 5'h00;
		case (p)
			1: return 5'h01;
			2: return 5'h02;
			3: return 5'h04;
			4, 5, 6, 7, 8: return 5'h08;
			14: return 5'h10;
			default: return 5'h00;
		endcase
	endfunction

	// Select a position, check how it is shown if it is nine or below, then check the pulses and the return to status.
	task automatic act(input int p);
		int j;
		logic [4:0] m;
		m = msk(p);
		s = cnt;
		i_op.select(p);
		for (j = 0; j < 3 && p <= 9; j++) chk(leds[j*2+:2], (j == (p - 1) % 3) ? 1 + (p - 1) / 3 : 0, "shown");
		cyc(DEB + CMT + 12);
		for (j = 0; j < 5; j++) chk(cnt[j] - s[j], m[j], "action pulse");
		chk(leds, 6'h15, "status restored");
	endtask

	task automatic cfgchk(input logic b, input logic n, input logic [31:0] ip, input logic [31:0] mg);
		chk({cfg_bridged, cfg_near}, {b, n}, "side and mode");
		chk(cfg_eth_ip, ip, "ethernet address");
		chk(cfg_mgmt_ip, mg, "management address");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, nv_lockout, cfg_cur_near} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		alm = 6'h00;
		site_alarm_pin = 2'h2;
		lock = 0;
		fr = {2'h0, 13'h16B1, 13'h166C, 4'h0};
		cyc(12);
		presetn <= 1'b1;
		cyc(8);
		chk(leds, 6'h15, "healthy");
		apb(1'b0, `FPAS_OFF_FREQ, 32'h0);
		chk(q, fr, "channel reset");
		for (i = 0; i < 5; i++) begin
			apb(1'b1, `FPAS_OFF_FREQ, {2'h0, frx[i], ftx[i], 2'h0, fpl[i]});
			chk(e, i == 1 || i == 3, "channel refusal");
			if (i != 1 && i != 3) fr = {2'h0, frx[i], ftx[i], 2'h0, fpl[i]};
			apb(1'b0, `FPAS_OFF_FREQ, 32'h0);
			chk(q, fr, "channel readback");
		end
		chk({freq_plan, tx_mhz, rx_mhz}, {fr[1:0], fr[16:4], fr[29:17]}, "channel outputs");
		apb(1'b0, 12'h010, 32'h0);
		chk({e, q[30:0]}, 32'h80000000, "unmapped");
		apb(1'b1, `FPAS_OFF_CONTROL, 32'h3);
		chk(relay_out, 2'h3, "relays");
		apb(1'b0, `FPAS_OFF_STATUS, 32'h0);
		chk(q[19:18], 2'h2, "site alarms");
		// Each alarm in turn: live colour, then a flashing history until cleared.
		for (i = 0; i < 6; i++) begin
			alm[i] <= 1'b1;
			cyc(4);
			chk(leds[(i/2)*2+:2], 2 + i % 2, "live colour");
			alm[i] <= 1'b0;
			cyc(2);
			s[0] = 0;
			s[1] = 0;
			repeat (20) begin
				@(posedge pclk);
				if (leds[(i/2)*2+:2] === 2'(2 + i % 2)) s[0] = 1;
				if (leds[(i/2)*2+:2] === 2'h0) s[1] = 2;
			end
			chk(s[0] + s[1], 3, "history flashes");
			if (i < 5) apb(1'b1, `FPAS_OFF_CONTROL, 32'h4);
			else act(1);
			cyc(4);
			chk(leds, 6'h15, "cleared");
		end
		cfg_cur_near <= 1'b1;
		for (i = 0; i < 11; i++) begin
			p = plist[i];
			act(p);
			case (p)
				4: cfgchk(1'b0, 1'b0, 32'h0A0B0102, 32'h0A0C0102);
				5: cfgchk(1'b0, 1'b1, 32'h0A020102, 32'h0A0D0102);
				6: cfgchk(1'b0, 1'b1, 32'h0A020102, 32'h0A0D0102);
				7: cfgchk(1'b1, 1'b0, BFAR, BFAR);
				8: cfgchk(1'b1, 1'b1, BNEAR, BNEAR);
				12: chk(trib_t1, 1'b0, "tributaries");
				13: chk(trib_t1, 1'b1, "tributaries");
				14: chk(wr_val, 1'b1, "lockout stored");
				default: ;
			endcase
		end
		apb(1'b0, `FPAS_OFF_CFG, 32'h0);
		chk(q, 32'h2, "config readback");
		lock = 1;
		act(4);
		act(2);
		i_op.select(15);
		chk(leds, 6'h00, "blank after overrun");
		act(1);
		// Power-on reset with the button held in re-enables every position.
		presetn <= 1'b0;
		nv_lockout <= 1'b1;
		i_op.hold(1'b1);
		cyc(12);
		s = cnt;
		presetn <= 1'b1;
		cyc(8);
		chk(cnt[4] - s[4], 1, "lockout undo pulse");
		chk(wr_val, 1'b0, "lockout undo value");
		nv_lockout <= 1'b0;
		i_op.hold(1'b0);
		cyc(DEB + CMT + 12);
		lock = 0;
		act(4);
		close_out();
	end

	// Watchdog: the sequence needs well under 6000 cycles, so 20000 means a hang.
	initial begin
		#(5 * 20000);
		n_mismatch++;
		close_out();
	end
endmodule
